// >>> design/lpmrb_cal_engine.sv
// Impedance calibration engine: timed calibration runs and default setting
`timescale 1ns/10ps
module lpmrb_cal_engine (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Requests
  lpmrb_cal_if.engine cal
);
  lpmrb_pkg::lpmrb_cal_state_type state_reg;
  logic [7:0] count_reg;
  logic default_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= lpmrb_pkg::LPMRB_CAL_IDLE;
      count_reg <= 8'h00;
    end else begin
      case (state_reg)
        lpmrb_pkg::LPMRB_CAL_IDLE: begin
          if (cal.start) begin
            state_reg <= lpmrb_pkg::LPMRB_CAL_RUN;
            case (cal.kind)
              lpmrb_pkg::LPMRB_KIND_LONG: count_reg <= lpmrb_pkg::CAL_LONG_CYC;
              lpmrb_pkg::LPMRB_KIND_SHORT: count_reg <= lpmrb_pkg::CAL_SHORT_CYC;
              default: count_reg <= lpmrb_pkg::CAL_RESET_CYC;
            endcase
          end
        end
        lpmrb_pkg::LPMRB_CAL_RUN: begin
          if (count_reg <= 8'h01) begin
            state_reg <= lpmrb_pkg::LPMRB_CAL_DONE;
          end
          count_reg <= count_reg - 8'h01;
        end
        lpmrb_pkg::LPMRB_CAL_DONE: state_reg <= lpmrb_pkg::LPMRB_CAL_IDLE;
        default: state_reg <= lpmrb_pkg::LPMRB_CAL_IDLE;
      endcase
    end
  end

  // Default setting is in force after power-up and after a reset command
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      default_reg <= 1'b1;
    end else if (cal.start) begin
      default_reg <= (cal.kind == lpmrb_pkg::LPMRB_KIND_RESET);
    end
  end

  assign cal.busy = (state_reg == lpmrb_pkg::LPMRB_CAL_RUN);
  assign cal.done = (state_reg == lpmrb_pkg::LPMRB_CAL_DONE);
  assign cal.default_cal = default_reg;
endmodule

// >>> design/lpmrb_cal_if.sv
// Interface carrying calibration requests to the calibration engine
`timescale 1ns/10ps
interface lpmrb_cal_if;
  logic start;
  lpmrb_pkg::lpmrb_cal_kind_type kind;
  logic busy;
  logic done;
  logic default_cal;
  modport bank(output start, output kind, input busy, input done, input default_cal);
  modport engine(input start, input kind, output busy, output done, output default_cal);
endinterface

// >>> design/lpmrb_mode_register_bank.sv
// Mode register bank for addresses 03h to 0Ah of a low-power DRAM
`timescale 1ns/10ps
module lpmrb_mode_register_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Mode register command port
  input wire logic mrw_i,
  input wire logic mrr_i,
  input wire logic [7:0] mode_addr_i,
  input wire logic [7:0] operand_bits_i,
  output logic [7:0] read_data_o,
  output logic read_valid_o,
  // Temperature sensor input, refresh-rate code from the sensor
  input wire logic [2:0] sensor_rate_i,
  // Calibration pin strap: high when tied to the core supply
  input wire logic calibration_pin_on_supply_i,
  // Block outputs
  output logic [3:0] drive_strength_field_o,
  output logic calibration_busy_o,
  output logic calibration_default_o,
  output logic derate_request_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] rate_meta_reg;
  logic [2:0] rate_sync_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;
  logic strap_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rate_meta_reg <= lpmrb_pkg::RATE_RESET;
      rate_sync_reg <= lpmrb_pkg::RATE_RESET;
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else begin
      rate_meta_reg <= sensor_rate_i;
      rate_sync_reg <= rate_meta_reg;
      strap_meta_reg <= calibration_pin_on_supply_i;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Strap is sampled continuously; its connection must not change after power-up
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      strap_reg <= 1'b0;
    end else begin
      strap_reg <= strap_sync_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Drive strength register
  logic [3:0] drive_reg;
  logic drive_code_ok;

  assign drive_code_ok = (operand_bits_i[3:0] != lpmrb_pkg::DRIVE_RSVD_LOW) &&
                         (operand_bits_i[3:0] != lpmrb_pkg::DRIVE_RSVD_MID) &&
                         (operand_bits_i[3:0] <= lpmrb_pkg::DRIVE_MAX_CODE);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      drive_reg <= lpmrb_pkg::DRIVE_RESET;
    end else if (mrw_i && mode_addr_i == lpmrb_pkg::ADDR_DRIVE_STRENGTH_CFG && drive_code_ok) begin
      drive_reg <= operand_bits_i[lpmrb_pkg::DRIVE_FIELD_LSB +: lpmrb_pkg::DRIVE_FIELD_W];
    end
  end

  assign drive_strength_field_o = drive_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Temperature and refresh-rate report
  logic [2:0] rate_reg;
  logic [2:0] rate_next;
  logic temp_update_flag_reg;
  logic report_read;

  // Sensor code 100b is reserved, hold the previous code instead
  always_comb begin
    if (rate_sync_reg == lpmrb_pkg::RATE_RSVD) begin
      rate_next = rate_reg;
    end else begin
      rate_next = rate_sync_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rate_reg <= lpmrb_pkg::RATE_RESET;
    end else begin
      rate_reg <= rate_next;
    end
  end

  assign report_read = mrr_i && (mode_addr_i == lpmrb_pkg::ADDR_TEMPERATURE_REFRESH_REPORT);

  // A change in the same cycle as a read wins, so it is never lost
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      temp_update_flag_reg <= 1'b0;
    end else if (rate_next != rate_reg) begin
      temp_update_flag_reg <= 1'b1;
    end else if (report_read) begin
      temp_update_flag_reg <= 1'b0;
    end
  end

  assign derate_request_o = (rate_reg == lpmrb_pkg::RATE_QUARTER_DERATE);

  //////////////////////////////////////////////////////////////////////////////
  // Calibration command decode
  lpmrb_cal_if cal_bus ();
  logic cal_write;
  logic cal_start;
  lpmrb_pkg::lpmrb_cal_kind_type cal_kind;

  assign cal_write = mrw_i && (mode_addr_i == lpmrb_pkg::ADDR_IMPEDANCE_CAL_COMMAND);

  always_comb begin
    case (operand_bits_i)
      lpmrb_pkg::CAL_LONG: cal_kind = lpmrb_pkg::LPMRB_KIND_LONG;
      lpmrb_pkg::CAL_AFTER_INIT: cal_kind = lpmrb_pkg::LPMRB_KIND_LONG;
      lpmrb_pkg::CAL_SHORT: cal_kind = lpmrb_pkg::LPMRB_KIND_SHORT;
      lpmrb_pkg::CAL_DEFAULT_RESET: cal_kind = lpmrb_pkg::LPMRB_KIND_RESET;
      default: cal_kind = lpmrb_pkg::LPMRB_KIND_NONE;
    endcase
  end

  // Supply strap blocks all calibration commands; a running or finishing calibration refuses new
  // ones, so a command is never half applied while the engine leaves its done state
  assign cal_start = cal_write && !strap_reg && !cal_bus.busy && !cal_bus.done &&
                     (cal_kind != lpmrb_pkg::LPMRB_KIND_NONE);

  assign cal_bus.start = cal_start;
  assign cal_bus.kind = cal_kind;

  lpmrb_cal_engine u_cal_engine (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cal(cal_bus.engine)
  );

  assign calibration_busy_o = cal_bus.busy;
  assign calibration_default_o = cal_bus.default_cal || strap_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [7:0] read_data_next;
  logic [7:0] read_data_reg;
  logic read_valid_reg;

  always_comb begin
    read_data_next = 8'h00;
    case (mode_addr_i)
      lpmrb_pkg::ADDR_TEMPERATURE_REFRESH_REPORT: begin
        read_data_next[lpmrb_pkg::TEMP_UPDATE_FLAG_BIT] = temp_update_flag_reg;
        read_data_next[2:0] = rate_reg;
      end
      lpmrb_pkg::ADDR_MAKER_IDENT: read_data_next = lpmrb_pkg::MAKER_IDENT_VALUE;
      lpmrb_pkg::ADDR_REVISION_IDENT_ONE: read_data_next = lpmrb_pkg::REVISION_ONE_VALUE;
      lpmrb_pkg::ADDR_REVISION_IDENT_TWO: read_data_next = lpmrb_pkg::REVISION_TWO_VALUE;
      lpmrb_pkg::ADDR_DEVICE_CONFIG_WORD: begin
        read_data_next = {lpmrb_pkg::WIDTH_X16, lpmrb_pkg::DENSITY_2GB,
                          lpmrb_pkg::TYPE_FOUR_PREFETCH};
      end
      lpmrb_pkg::ADDR_VENDOR_TEST_REG: read_data_next = 8'h00;
      default: read_data_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      read_data_reg <= 8'h00;
      read_valid_reg <= 1'b0;
    end else begin
      read_valid_reg <= mrr_i;
      if (mrr_i) begin
        read_data_reg <= read_data_next;
      end
    end
  end

  assign read_data_o = read_data_reg;
  assign read_valid_o = read_valid_reg;

endmodule

// >>> design/lpmrb_pkg.sv
// Package of constants for the low-power DRAM mode register bank
package lpmrb_pkg;
  // Mode register addresses
  localparam logic [7:0] ADDR_DRIVE_STRENGTH_CFG = 8'h03;
  localparam logic [7:0] ADDR_TEMPERATURE_REFRESH_REPORT = 8'h04;
  localparam logic [7:0] ADDR_MAKER_IDENT = 8'h05;
  localparam logic [7:0] ADDR_REVISION_IDENT_ONE = 8'h06;
  localparam logic [7:0] ADDR_REVISION_IDENT_TWO = 8'h07;
  localparam logic [7:0] ADDR_DEVICE_CONFIG_WORD = 8'h08;
  localparam logic [7:0] ADDR_VENDOR_TEST_REG = 8'h09;
  localparam logic [7:0] ADDR_IMPEDANCE_CAL_COMMAND = 8'h0A;
  // Drive strength field
  localparam int DRIVE_FIELD_LSB = 0;
  localparam int DRIVE_FIELD_W = 4;
  localparam logic [3:0] DRIVE_RSVD_LOW = 4'h0;
  localparam logic [3:0] DRIVE_RSVD_MID = 4'h5;
  localparam logic [3:0] DRIVE_MAX_CODE = 4'h7;
  localparam logic [3:0] DRIVE_RESET = 4'h2;
  // Temperature report fields
  localparam int TEMP_UPDATE_FLAG_BIT = 7;
  localparam int HOT_BIT = 2;
  localparam logic [2:0] RATE_LOW_LIMIT = 3'h0;
  localparam logic [2:0] RATE_X4 = 3'h1;
  localparam logic [2:0] RATE_X2 = 3'h2;
  localparam logic [2:0] RATE_X1 = 3'h3;
  localparam logic [2:0] RATE_RSVD = 3'h4;
  localparam logic [2:0] RATE_QUARTER = 3'h5;
  localparam logic [2:0] RATE_QUARTER_DERATE = 3'h6;
  localparam logic [2:0] RATE_HIGH_LIMIT = 3'h7;
  localparam logic [2:0] RATE_RESET = 3'h3;
  // Identification values, arbitrary neutral values
  localparam logic [7:0] MAKER_IDENT_VALUE = 8'h5A;
  localparam logic [7:0] REVISION_ONE_VALUE = 8'h01;
  localparam logic [7:0] REVISION_TWO_VALUE = 8'h01;
  // Configuration word fields
  localparam logic [1:0] TYPE_FOUR_PREFETCH = 2'h0;
  localparam logic [3:0] DENSITY_2GB = 4'h5;
  localparam logic [1:0] WIDTH_X16 = 2'h1;
  // Calibration command codes
  localparam logic [7:0] CAL_AFTER_INIT = 8'hFF;
  localparam logic [7:0] CAL_LONG = 8'hAB;
  localparam logic [7:0] CAL_SHORT = 8'h56;
  localparam logic [7:0] CAL_DEFAULT_RESET = 8'hC3;
  // Calibration busy times in cycles at 20 MHz
  localparam int CLK_MHZ = 20;
  localparam int CAL_LONG_NS = 1000;
  localparam int CAL_SHORT_NS = 100;
  localparam int CAL_RESET_NS = 50;
  localparam logic [7:0] CAL_LONG_CYC = 8'((CAL_LONG_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] CAL_SHORT_CYC = 8'((CAL_SHORT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] CAL_RESET_CYC = 8'((CAL_RESET_NS * CLK_MHZ + 999) / 1000);
  // Calibration engine states
  typedef enum logic [1:0] {
    LPMRB_CAL_IDLE = 2'b00,
    LPMRB_CAL_RUN = 2'b01,
    LPMRB_CAL_DONE = 2'b11
  } lpmrb_cal_state_type;
  typedef enum logic [1:0] {
    LPMRB_KIND_NONE = 2'b00,
    LPMRB_KIND_LONG = 2'b01,
    LPMRB_KIND_SHORT = 2'b10,
    LPMRB_KIND_RESET = 2'b11
  } lpmrb_cal_kind_type;
endpackage

// >>> tb/lpmrb_bank_monitor.sv
// Checker of the mode register bank ports
`timescale 1ns/10ps
module lpmrb_bank_monitor (
  // Clock, reset and command port
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic mrw_i,
  input wire logic mrr_i,
  input wire logic [7:0] mode_addr_i,
  input wire logic [7:0] operand_bits_i,
  // Strap and outputs
  input wire logic [7:0] read_data_o,
  input wire logic read_valid_o,
  input wire logic calibration_pin_on_supply_i,
  input wire logic [3:0] drive_strength_field_o,
  input wire logic calibration_busy_o,
  input wire logic calibration_default_o
);
  logic [3:0] strap_reg;
  logic busy_reg;
  logic cal_wr, cal_ok, drv_ok;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Last four strap samples, cleared by reset; busy one cycle back
  always_ff @(posedge clk_i) begin
    strap_reg <= sys_rst_i ? 4'h0 : {strap_reg[2:0], calibration_pin_on_supply_i};
    busy_reg <= calibration_busy_o;
  end
  assign cal_wr = mrw_i && mode_addr_i == 8'h0A && !calibration_busy_o && !busy_reg;
  assign cal_ok = cal_wr && strap_reg == 4'h0 && !calibration_pin_on_supply_i;
  assign drv_ok = operand_bits_i[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
  property p_drv_set;
    mrw_i && mode_addr_i == 8'h03 && drv_ok
      |=> {4'h0, drive_strength_field_o} == ($past(operand_bits_i) & 8'h0F);
  endproperty
  a_drv_set: assert property (p_drv_set) else $error("drive code not taken");
  property p_drv_keep;
    mrw_i && mode_addr_i == 8'h03 && !drv_ok |=> $stable(drive_strength_field_o);
  endproperty
  a_drv_keep: assert property (p_drv_keep) else $error("reserved drive taken");
  property p_maker;
    mrr_i && mode_addr_i == 8'h05 |=> read_data_o == lpmrb_pkg::MAKER_IDENT_VALUE;
  endproperty
  a_maker: assert property (p_maker) else $error("maker byte wrong");
  property p_cfg;
    mrr_i && mode_addr_i == 8'h08 |=> read_valid_o && read_data_o == 8'h54;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config word wrong");
  property p_long;
    cal_ok && operand_bits_i == 8'hAB |=> (calibration_busy_o && !calibration_default_o) [*8];
  endproperty
  a_long: assert property (p_long) else $error("long run not held");
  property p_zrst;
    cal_ok && operand_bits_i == 8'hC3 |=> calibration_default_o ##1 !calibration_busy_o;
  endproperty
  a_zrst: assert property (p_zrst) else $error("default reset wrong");
  property p_rsvd;
    cal_wr && !(operand_bits_i inside {8'hFF, 8'hAB, 8'h56, 8'hC3}) |=> !calibration_busy_o;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code ran");
  property p_strap;
    cal_wr && strap_reg == 4'hF |=> !calibration_busy_o && calibration_default_o;
  endproperty
  a_strap: assert property (p_strap) else $error("strap command ran");
endmodule
bind lpmrb_mode_register_bank lpmrb_bank_monitor u_lpmrb_bank_monitor (
  .clk_i, .sys_rst_i, .mrw_i, .mrr_i, .mode_addr_i, .operand_bits_i, .read_data_o,
  .read_valid_o, .calibration_pin_on_supply_i, .drive_strength_field_o,
  .calibration_busy_o, .calibration_default_o
);

// >>> tb/lpmrb_ctrl_model.sv
// Controller model issuing mode register commands
`timescale 1ns/10ps
module lpmrb_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Strobes, address and data
  output logic mrw_o = 1'b0,
  output logic mrr_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] data_o = 8'h00,
  // Read answer
  input wire logic [7:0] read_data_i,
  input wire logic read_valid_i
);
  logic [7:0] rdata;
  logic rvalid;
  // One idle edge, then one strobe cycle; released lines show the inverse
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    mrw_o = w;
    mrr_o = !w;
    addr_o = a;
    data_o = d;
    @(posedge clk_i);
    #1;
    mrw_o = 1'b0;
    mrr_o = 1'b0;
    addr_o = ~a;
    data_o = ~d;
    rdata = read_data_i;
    rvalid = read_valid_i;
  endtask
endmodule

// >>> tb/test_lp_dram_mode_register_bank.sv
// Self-checking bench of the mode register bank
`timescale 1ns/10ps
module test_lp_dram_mode_register_bank;
  logic clk_i = 1'b0;
  logic sys_rst_i, calibration_pin_on_supply_i, calibration_busy_o, calibration_default_o;
  logic mrw_i, mrr_i, read_valid_o, derate_request_o;
  logic [7:0] mode_addr_i, operand_bits_i, read_data_o, c;
  logic [3:0] drive_strength_field_o, drv;
  logic [2:0] sensor_rate_i, rate, last;
  logic [7:0] ra [9] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h03, 8'h0A, 8'h20, 8'h04};
  logic [7:0] re [9] = '{lpmrb_pkg::MAKER_IDENT_VALUE, lpmrb_pkg::REVISION_ONE_VALUE,
    lpmrb_pkg::REVISION_TWO_VALUE, 8'h54, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  logic [7:0] cc [5] = '{8'hFF, 8'hC3, 8'hAB, 8'h56, 8'h00};
  int n_fail, checked, n;
  initial forever #25 clk_i = ~clk_i;
  lpmrb_mode_register_bank u_lpmrb_mode_register_bank (
    .clk_i, .sys_rst_i, .mrw_i, .mrr_i, .mode_addr_i, .operand_bits_i, .read_data_o,
    .read_valid_o, .sensor_rate_i, .calibration_pin_on_supply_i, .drive_strength_field_o,
    .calibration_busy_o, .calibration_default_o, .derate_request_o
  );
  lpmrb_ctrl_model u_lpmrb_ctrl_model (.clk_i, .mrw_o(mrw_i), .mrr_o(mrr_i),
    .addr_o(mode_addr_i), .data_o(operand_bits_i), .read_data_i(read_data_o),
    .read_valid_i(read_valid_o));
  function automatic logic [3:0] exp_drive(input logic [3:0] o, input logic [3:0] k);
    return (k inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7}) ? k : o;
  endfunction
  function automatic logic [7:0] cal_len(input logic [7:0] k);
    return (k == 8'hC3) ? lpmrb_pkg::CAL_RESET_CYC : (k == 8'h56) ? lpmrb_pkg::CAL_SHORT_CYC
      : (k == 8'hFF || k == 8'hAB) ? lpmrb_pkg::CAL_LONG_CYC : 8'h00;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_lpmrb_ctrl_model.cmd(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_lpmrb_ctrl_model.cmd(1'b0, a, 8'h00);
    chk({7'h0, u_lpmrb_ctrl_model.rvalid}, 8'h01);
    chk(u_lpmrb_ctrl_model.rdata, e);
  endtask
  task automatic end_sim;
    $display("Counts: checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    settle(20000);
    n_fail++;
    end_sim();
  end
  initial begin
    n = $urandom(32'h629F3835);
    sensor_rate_i = 3'h3;
    // Strap tied high first, then low; a power cycle between the two
    for (int s = 1; s >= 0; s--) begin
      calibration_pin_on_supply_i = s[0];
      sys_rst_i = 1'b1;
      settle(10);
      sys_rst_i = 1'b0;
      settle(4);
      chk({drive_strength_field_o, 2'h0, calibration_busy_o, calibration_default_o}, 8'h21);
      wr(8'h0A, 8'hC3);
      chk({6'h0, calibration_busy_o, calibration_default_o}, {6'h0, !s[0], 1'b1});
      settle(2);
    end
    wr(8'h08, 8'hFF);
    for (int i = 0; i < 9; i++) begin
      rdc(ra[i], re[i]);
    end
    drv = 4'h2;
    for (int i = 0; i < 24; i++) begin
      c = {4'($urandom), (i < 16) ? 4'(i) : 4'($urandom)};
      wr(8'h03, c);
      drv = exp_drive(drv, c[3:0]);
      chk({4'h0, drive_strength_field_o}, {4'h0, drv});
    end
    rate = 3'h3;
    last = 3'h3;
    for (int i = 0; i < 20; i++) begin
      sensor_rate_i = (i < 8) ? 3'(i) : 3'($urandom);
      settle(4);
      rate = (sensor_rate_i == 3'h4) ? rate : sensor_rate_i;
      rdc(8'h04, {rate != last, 4'h0, rate});
      chk({7'h0, derate_request_o}, {7'h0, rate == 3'h6});
      rdc(8'h04, {5'h0, rate});
      last = rate;
    end
    cc[4] = 8'($urandom) & 8'h3C;
    for (int i = 0; i < 5; i++) begin
      wr(8'h0A, cc[i]);
      chk({calibration_busy_o, calibration_default_o}, {cal_len(cc[i]) != 0, cc[i] == 8'hC3});
      n = 0;
      while (calibration_busy_o === 1'b1 && n < 99) begin
        n++;
        settle(1);
      end
      chk(8'(n), cal_len(cc[i]));
      settle(2);
    end
    end_sim();
  end
endmodule
